// File: rtl/ncpr_host.sv
// nand page-read host controller with its read-data fifo
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// fifo between the pin reader and the user
// ************************************************************
module ncpr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != FULL_CNT);
   assign push = in_valid && in_ready;
   // output stage is a register so the consumer sees flop outputs
   assign pop = (count != '0) && (!out_valid || out_ready);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : ncpr_fifo

// ************************************************************
// host sequencer
// ************************************************************
module ncpr_host #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start,
   input wire logic two_plane,
   input wire logic poll_status,
   input wire logic [ncpr_pkg::ROW_W-1:0] row_addr,
   input wire logic [ncpr_pkg::COL_W-1:0] col_addr,
   input wire logic [ncpr_pkg::LEN_W-1:0] byte_count,
   output logic busy,
   output logic done,
   output logic dout_valid,
   output logic [7:0] dout_data,
   input wire logic dout_ready,
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic nand_re_n,
   output logic [7:0] nand_io_out,
   output logic nand_io_oe,
   input wire logic [7:0] nand_io_in,
   input wire logic ready_busy_n
);
   import ncpr_pkg::*;

   ncpr_state_t state;
   logic [4:0] step;
   logic [CNT_W-1:0] cnt;
   logic re_hi;
   logic stat_mode;
   logic [LEN_W-1:0] rem;
   logic [LEN_W-1:0] len;
   logic [ROW_W-1:0] row;
   logic [COL_W-1:0] col;
   logic two;
   logic poll;
   logic [7:0] io_s1, io_s2, io_s3;
   logic rb_s1, rb_s2, rb_s3, rb_ready;
   logic f_valid;
   logic [7:0] f_data;
   logic f_ready;
   ncpr_step_t cur;

   // ************************************************************
   // step program
   // ************************************************************
   function automatic ncpr_step_t mk(input ncpr_kind_t k, input logic p,
                                     input logic [4:0] ai, input logic [7:0] c);
      ncpr_step_t r;
      r.kind = k;
      r.plane = p;
      r.aidx = ai[2:0];
      r.code = c;
      return r;
   endfunction : mk

   // only codes from the defined set ever appear here, 78h never does
   function automatic ncpr_step_t step_of(input logic tp, input logic [4:0] s);
      ncpr_step_t r;
      r = mk(K_END, 1'b0, 5'h00, 8'h00);
      if (!tp) begin
         if (s == 5'h00) r = mk(K_CMD, 1'b0, 5'h00, CMD_READ);
         else if (s <= 5'h05) r = mk(K_ADDR, 1'b0, s - 5'h01, 8'h00);
         else if (s == 5'h06) r = mk(K_CMD, 1'b0, 5'h00, CMD_READ_GO);
         else if (s == 5'h07) r = mk(K_WAIT, 1'b0, 5'h00, 8'h00);
         else if (s == 5'h08) r = mk(K_CMD, 1'b0, 5'h00, CMD_READ);
         else if (s == 5'h09) r = mk(K_READ, 1'b0, 5'h00, 8'h00);
      end else begin
         if (s == 5'h00) r = mk(K_CMD, 1'b0, 5'h00, CMD_READ);
         else if (s <= 5'h05) r = mk(K_ADDR, 1'b0, s - 5'h01, 8'h00);
         else if (s == 5'h06) r = mk(K_CMD, 1'b0, 5'h00, CMD_READ);
         else if (s <= 5'h0b) r = mk(K_ADDR, 1'b1, s - 5'h07, 8'h00);
         else if (s == 5'h0c) r = mk(K_CMD, 1'b0, 5'h00, CMD_READ_GO);
         else if (s == 5'h0d) r = mk(K_WAIT, 1'b0, 5'h00, 8'h00);
         else if (s == 5'h0e) r = mk(K_CMD, 1'b0, 5'h00, CMD_PLANE_SEL);
         else if (s <= 5'h13) r = mk(K_ADDR, 1'b0, s - 5'h0f, 8'h00);
         else if (s == 5'h14) r = mk(K_CMD, 1'b0, 5'h00, CMD_OUT_GO);
         else if (s == 5'h15) r = mk(K_READ, 1'b0, 5'h00, 8'h00);
         else if (s == 5'h16) r = mk(K_CMD, 1'b0, 5'h00, CMD_PLANE_SEL);
         else if (s <= 5'h1b) r = mk(K_ADDR, 1'b1, s - 5'h17, 8'h00);
         else if (s == 5'h1c) r = mk(K_CMD, 1'b0, 5'h00, CMD_OUT_GO);
         else if (s == 5'h1d) r = mk(K_READ, 1'b0, 5'h00, 8'h00);
      end
      return r;
   endfunction : step_of

   // column in two cycles, row in three, low-order bits first
   function automatic logic [7:0] addr_byte(input ncpr_step_t st);
      logic [ROW_W-1:0] r;
      logic [7:0] b;
      r = row;
      if (two) r[ROW_PLANE_BIT] = st.plane;
      unique case (st.aidx)
         3'h0: b = col[7:0];
         3'h1: b = {4'h0, col[11:8]};
         3'h2: b = r[7:0];
         3'h3: b = r[15:8];
         default: b = {7'h00, r[16]};
      endcase
      return b;
   endfunction : addr_byte

   assign cur = step_of(two, step);

   // ************************************************************
   // input synchronisers
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         io_s1 <= 8'h00;
         io_s2 <= 8'h00;
         io_s3 <= 8'h00;
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
         rb_s3 <= 1'b1;
         rb_ready <= 1'b1;
      end else begin
         io_s1 <= nand_io_in;
         io_s2 <= io_s1;
         io_s3 <= io_s2;
         rb_s1 <= ready_busy_n;
         rb_s2 <= rb_s1;
         rb_s3 <= rb_s2;
         if (rb_s2 == rb_s3) begin
            rb_ready <= rb_s3;
         end
      end
   end

   // ************************************************************
   // sequencer and pins
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= ST_IDLE;
         step <= 5'h00;
         cnt <= '0;
         re_hi <= 1'b0;
         stat_mode <= 1'b0;
         rem <= '0;
         len <= '0;
         row <= '0;
         col <= '0;
         two <= 1'b0;
         poll <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         f_valid <= 1'b0;
         f_data <= 8'h00;
         nand_ce_n <= 1'b1;
         nand_cle <= 1'b0;
         nand_ale <= 1'b0;
         nand_we_n <= 1'b1;
         nand_re_n <= 1'b1;
         nand_io_out <= 8'h00;
         nand_io_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         f_valid <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  two <= two_plane;
                  poll <= poll_status;
                  row <= row_addr;
                  col <= col_addr;
                  len <= byte_count;
                  step <= 5'h00;
                  busy <= 1'b1;
                  nand_ce_n <= 1'b0;
                  state <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               cnt <= '0;
               unique case (cur.kind)
                  K_CMD, K_ADDR: begin
                     nand_cle <= (cur.kind == K_CMD);
                     nand_ale <= (cur.kind == K_ADDR);
                     nand_io_out <= (cur.kind == K_CMD) ? cur.code : addr_byte(cur);
                     nand_io_oe <= 1'b1;
                     nand_we_n <= 1'b0;
                     state <= ST_WR;
                  end
                  K_WAIT: begin
                     state <= ST_BUSY;
                  end
                  K_READ: begin
                     rem <= len;
                     re_hi <= 1'b0;
                     state <= ST_RD;
                  end
                  K_END: begin
                     nand_ce_n <= 1'b1;
                     busy <= 1'b0;
                     done <= 1'b1;
                     state <= ST_IDLE;
                  end
               endcase
            end
            ST_WR: begin
               cnt <= cnt + 1'b1;
               // bus value latched by the device on this rising edge
               if (cnt == CNT_W'(WP_CYC - 1)) begin
                  nand_we_n <= 1'b1;
               end
               if (cnt == CNT_W'(WP_CYC + HOLD_CYC - 1)) begin
                  nand_cle <= 1'b0;
                  nand_ale <= 1'b0;
                  nand_io_oe <= 1'b0;
                  cnt <= '0;
                  re_hi <= 1'b0;
                  if (stat_mode) begin
                     state <= ST_RD;
                  end else begin
                     step <= step + 5'h01;
                     state <= ST_FETCH;
                  end
               end
            end
            ST_BUSY: begin
               // rb may lag the confirm by the busy delay plus synchroniser
               if (cnt != CNT_W'(WB_CYC)) begin
                  cnt <= cnt + 1'b1;
               end else if (poll) begin
                  nand_cle <= 1'b1;
                  nand_io_out <= CMD_STATUS;
                  nand_io_oe <= 1'b1;
                  nand_we_n <= 1'b0;
                  stat_mode <= 1'b1;
                  cnt <= '0;
                  state <= ST_WR;
               end else if (rb_ready) begin
                  step <= step + 5'h01;
                  state <= ST_FETCH;
               end
            end
            ST_RD: begin
               if (re_hi) begin
                  cnt <= cnt + 1'b1;
                  if (cnt == CNT_W'(RE_HIGH_CYC - 1)) begin
                     re_hi <= 1'b0;
                  end
               end else if (nand_re_n) begin
                  if (!stat_mode && rem == '0) begin
                     step <= step + 5'h01;
                     state <= ST_FETCH;
                  end else if (stat_mode || f_ready) begin
                     // a data pulse starts only when the fifo has room, a status pulse at once
                     nand_re_n <= 1'b0;
                     cnt <= '0;
                  end
               end else if (cnt != CNT_W'(RE_LOW_CYC - 1)) begin
                  cnt <= cnt + 1'b1;
               end else if (io_s2 == io_s3) begin
                  nand_re_n <= 1'b1;
                  re_hi <= 1'b1;
                  cnt <= '0;
                  if (stat_mode) begin
                     // keep polling until loads report done
                     if (io_s3[STAT_RDY_BIT]) begin
                        stat_mode <= 1'b0;
                        step <= step + 5'h01;
                        state <= ST_FETCH;
                     end
                  end else begin
                     f_data <= io_s3;
                     f_valid <= 1'b1;
                     rem <= rem - 1'b1;
                  end
               end
            end
         endcase
      end
   end

   ncpr_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rst_n(rstn),
      .in_valid(f_valid),
      .in_data(f_data),
      .in_ready(f_ready),
      .out_valid(dout_valid),
      .out_data(dout_data),
      .out_ready(dout_ready)
   );
endmodule : ncpr_host

`default_nettype wire

// File: rtl/ncpr_pkg.sv
// shared constants and types of the nand page-read host controller
package ncpr_pkg;
   // ************************************************************
   // clock and pin timing
   // ************************************************************
   localparam int CLK_NS = 100;
   localparam int T_WP_NS = 25;
   localparam int T_WHR_NS = 80;
   localparam int T_REA_NS = 25;
   localparam int T_REH_NS = 15;
   localparam int T_WB_NS = 100;
   localparam int SYNC_STAGES = 3;
   // least times round up, never below one cycle
   function automatic int min_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : min_cyc
   localparam int WP_CYC = min_cyc(T_WP_NS);
   localparam int HOLD_CYC = min_cyc(T_WHR_NS);
   // read strobe low long enough for data plus the input synchroniser
   localparam int RE_LOW_CYC = min_cyc(T_REA_NS) + SYNC_STAGES;
   localparam int RE_HIGH_CYC = min_cyc(T_REH_NS);
   localparam int WB_CYC = min_cyc(T_WB_NS) + SYNC_STAGES;
   localparam int CNT_W = 4;

   // ************************************************************
   // command codes and address layout
   // ************************************************************
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_PLANE_SEL = 8'h06;
   localparam logic [7:0] CMD_OUT_GO = 8'he0;
   localparam int STAT_RDY_BIT = 6;
   localparam int COL_W = 12;
   localparam int ROW_W = 17;
   localparam int LEN_W = 12;
   localparam int ROW_PLANE_BIT = 6;
   localparam int ADDR_CYCLES = 5;

   // ************************************************************
   // sequencer types
   // ************************************************************
   typedef enum logic [4:0] {
      K_CMD = 5'b00001,
      K_ADDR = 5'b00010,
      K_WAIT = 5'b00100,
      K_READ = 5'b01000,
      K_END = 5'b10000
   } ncpr_kind_t;

   typedef struct packed {
      ncpr_kind_t kind;
      logic plane;
      logic [2:0] aidx;
      logic [7:0] code;
   } ncpr_step_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_FETCH = 5'b00010,
      ST_WR = 5'b00100,
      ST_BUSY = 5'b01000,
      ST_RD = 5'b10000
   } ncpr_state_t;
endpackage : ncpr_pkg

// File: dv/ncpr_host_props.sv
// bound pin checker of the nand page-read host
`timescale 1ns/1ps
`default_nettype none
module ncpr_host_props (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start,
   input wire logic poll_status,
   input wire logic busy,
   input wire logic done,
   input wire logic dout_valid,
   input wire logic [7:0] dout_data,
   input wire logic dout_ready,
   input wire logic nand_ce_n,
   input wire logic nand_cle,
   input wire logic nand_ale,
   input wire logic nand_we_n,
   input wire logic nand_re_n,
   input wire logic [7:0] nand_io_out,
   input wire logic nand_io_oe,
   input wire logic ready_busy_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ************************************************************
   // assertions
   // ************************************************************
   a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> nand_ce_n && nand_we_n
      && nand_re_n && !nand_io_oe && !nand_cle && !busy && !done) else $error("pins not idle");
   a_start_taken: assert property (
      start && !busy |=> busy && !nand_ce_n) else $error("start not taken");
   a_done_ends: assert property (
      done |-> !busy && nand_ce_n ##1 !done) else $error("done not a lone pulse");
   a_idle_pins: assert property (
      !busy |-> nand_ce_n && nand_we_n && nand_re_n) else $error("strobe while idle");
   a_we_hold: assert property (
      !nand_we_n |=> nand_we_n && nand_io_oe && $stable(nand_io_out) && $stable(nand_cle)
      && $stable(nand_ale)) else $error("write byte unstable at latch edge");
   a_latch_one: assert property (
      nand_io_oe |-> nand_cle ^ nand_ale) else $error("bus driven without one latch strobe");
   a_cmd_known: assert property (
      $rose(nand_we_n) && nand_cle |-> nand_io_out inside {8'h00, 8'h30, 8'h70, 8'h06, 8'he0})
      else $error("undefined command sent");
   a_re_quiet: assert property (
      !nand_re_n |-> !nand_io_oe && nand_we_n && !nand_cle && !nand_ale)
      else $error("read strobe while writing");
   a_re_width: assert property (
      $fell(nand_re_n) |-> (!nand_re_n) [*4]) else $error("read strobe too short");
   a_wait_ready: assert property (
      !ready_busy_n && !poll_status |-> nand_re_n) else $error("read while device busy");
   a_fifo_hold: assert property (
      dout_valid && !dout_ready |=> dout_valid && $stable(dout_data)) else $error("word lost");
endmodule : ncpr_host_props

bind ncpr_host ncpr_host_props ncpr_host_props_i (.mclk(mclk), .rstn(rstn), .start(start),
   .poll_status(poll_status), .busy(busy), .done(done), .dout_valid(dout_valid),
   .dout_data(dout_data), .dout_ready(dout_ready), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
   .nand_ale(nand_ale), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
   .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire

// File: dv/ncpr_flash_model.sv
// behavioural nand device answering the page-read host
`timescale 1ns/1ps
`default_nettype none
module ncpr_flash_model #(
   parameter int LOAD_NS = 3000
) (
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic [7:0] io_out,
   output logic [7:0] io_in,
   output logic ready_busy_n
);
   logic [7:0] cmd = 8'h00;
   logic [39:0] adr = '0;
   logic [11:0] col = '0;
   logic [16:0] row = '0;
   logic stat = 1'b0;
   int na = 0;
   initial io_in = 8'h00;
   initial ready_busy_n = 1'b1;
   // ************************************************************
   // command and address capture
   // ************************************************************
   always @(posedge we_n) begin
      if (!ce_n && cle && (ready_busy_n || io_out == 8'h70)) begin
         cmd = io_out;
         na = 0;
         // status output stays until 00h or 06h is issued
         stat = io_out == 8'h70 || (stat && io_out != 8'h00 && io_out != 8'h06);
         // only a final confirm starts the array, never 11h or d1h
         if (io_out inside {8'h30, 8'h35, 8'h10, 8'hd0}) begin
            ready_busy_n = 1'b0;
            ready_busy_n <= #(LOAD_NS) 1'b1;
         end
         if (io_out == 8'he0) begin
            col = adr[11:0];
            row = adr[32:16];
         end
      end else if (!ce_n && ale && na < 5) begin
         adr[8*na +: 8] = io_out;
         na++;
         if (na == 5 && cmd == 8'h00) begin
            col = adr[11:0];
            row = adr[32:16];
         end
      end
   end
   // ************************************************************
   // data and status output
   // ************************************************************
   always @(negedge re_n) begin
      if (!ce_n)
         io_in = stat ? {1'b0, ready_busy_n, 6'h00} :
            col[7:0] ^ row[7:0] ^ row[15:8] ^ {3'h0, row[16], col[11:8]};
   end
   // released bus shows the inverse so a stale byte never passes
   always @(posedge re_n) begin
      if (!ce_n && !stat)
         col++;
      io_in = ~io_in;
   end
endmodule : ncpr_flash_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the nand page-read host
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ncpr_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0, two_plane = 1'b0, poll_status = 1'b0, dout_ready = 1'b0;
   logic [ROW_W-1:0] row_addr = '0;
   logic [COL_W-1:0] col_addr = '0;
   logic [LEN_W-1:0] byte_count = '0;
   logic busy, done, dout_valid, nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n;
   logic nand_io_oe, rb_n;
   logic [7:0] dout_data, nand_io_out, mdl_io, bus;
   logic [63:0] cmds = '0;
   int ncmd = 0, re_falls = 0, bad_count = 0, checked = 0;
   assign bus = nand_io_oe ? nand_io_out : mdl_io;
   ncpr_host #(.FIFO_DEPTH(16)) ncpr_host_i (.mclk(mclk), .rstn(rstn), .start(start),
      .two_plane(two_plane), .poll_status(poll_status), .row_addr(row_addr),
      .col_addr(col_addr), .byte_count(byte_count), .busy(busy), .done(done),
      .dout_valid(dout_valid), .dout_data(dout_data), .dout_ready(dout_ready),
      .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
      .nand_re_n(nand_re_n), .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe),
      .nand_io_in(bus), .ready_busy_n(rb_n));
   ncpr_flash_model #(.LOAD_NS(3000)) ncpr_flash_model_i (.ce_n(nand_ce_n), .cle(nand_cle),
      .ale(nand_ale), .we_n(nand_we_n), .re_n(nand_re_n), .io_out(nand_io_out),
      .io_in(mdl_io), .ready_busy_n(rb_n));
   initial forever #50 mclk = ~mclk;
   always @(negedge nand_re_n) re_falls++;
   always @(posedge nand_we_n) begin
      if (nand_cle === 1'b1) begin
         cmds = {cmds[55:0], nand_io_out};
         ncmd++;
      end
   end
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   function automatic logic [7:0] pat(input logic [11:0] cc, input logic [16:0] rr);
      return cc[7:0] ^ rr[7:0] ^ rr[15:8] ^ {3'h0, rr[16], cc[11:8]};
   endfunction : pat
   task automatic run(input logic tp, input logic pl, input logic [16:0] r,
         input logic [11:0] c, input int n, input int stall, input int xn, input logic [63:0] xc);
      int k, got, tot, nd, r0;
      logic [16:0] rr;
      tot = tp ? 2 * n : n;
      got = 0;
      nd = 0;
      r0 = re_falls;
      cmds = '0;
      ncmd = 0;
      @(negedge mclk);
      two_plane = tp;
      poll_status = pl;
      row_addr = r;
      col_addr = c;
      byte_count = n[11:0];
      start = 1'b1;
      // the second cycle of start falls while busy and must leave no trace
      repeat (2) @(negedge mclk);
      start = 1'b0;
      for (k = 0; k < 9000; k++) begin
         // ready first, so the word taken at the next edge is the one judged
         dout_ready = (k >= stall);
         if (done === 1'b1)
            nd++;
         if (dout_valid === 1'b1 && dout_ready === 1'b1) begin
            rr = tp ? {r[16:7], got >= n, r[5:0]} : r;
            check("dout_data", dout_data, pat(c + 12'(got % n), rr));
            got++;
         end
         // fifo words, output stage and one pulse in flight at the most
         if (k == stall && stall > 0)
            check("strobes_held", re_falls - r0 <= 18, 1'b1);
         if (got == tot && nd > 0)
            break;
         @(negedge mclk);
      end
      if (k == 9000) begin
         check("timeout", 1'b1, 1'b0);
         results();
      end
      if (xn > 0) begin
         check("cmd_count", ncmd, xn);
         check("cmd_codes", cmds, xc);
      end
      repeat (5) @(negedge mclk);
      check("done_once", nd, 1);
      check("idle_after", busy, 1'b0);
   endtask : run
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_single();
      run(1'b0, 1'b0, 17'h0a5c3, 12'h3fd, 6, 0, 3, 64'h3000);
      $display("t_single over");
   endtask : t_single
   task automatic t_poll();
      run(1'b0, 1'b1, 17'h1f00e, 12'h010, 4, 0, 4, 64'h307000);
      $display("t_poll over");
   endtask : t_poll
   task automatic t_two();
      run(1'b1, 1'b0, 17'h12345, 12'h7fe, 5, 0, 7, 64'h3006e006e0);
      $display("t_two over");
   endtask : t_two
   task automatic t_two_poll();
      run(1'b1, 1'b1, 17'h0ab80, 12'h001, 3, 0, 8, 64'h307006e006e0);
      $display("t_two_poll over");
   endtask : t_two_poll
   task automatic t_zero();
      run(1'b0, 1'b0, 17'h00010, 12'h000, 0, 0, 0, 64'h0);
      $display("t_zero over");
   endtask : t_zero
   task automatic t_stall();
      run(1'b0, 1'b0, 17'h05a5a, 12'h100, 40, 300, 3, 64'h3000);
      $display("t_stall over");
   endtask : t_stall
   initial begin
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      t_single();
      t_poll();
      t_two();
      t_two_poll();
      t_zero();
      t_stall();
      results();
   end
endmodule : testbench
`default_nettype wire
